// [hw/fcm_pkg.sv]
// Shared constants, types and register map of the force-compare and channel-7 mask block.
// Function
// R1: Writing force bits triggers each selected channel's configured compare action at once.
// R2: A forced action equals a genuine match, but leaves the channel flag unchanged.
// R3: The force register is always writable and always reads as zero.
// R4: A channel-7 event (overflow with toggle enable, or match) overrides channel 6:0 compares.
// R5: A force and a genuine match together: force action wins, flag not set.
// R6: Mask bit one: a channel-7 event drives that pin to its channel-7 data bit.
// R7: Mask bit zero: a channel-7 event leaves that pin untouched.
// R8: Channel-7 data reaches a pin only if compare selected and pin connected.
// R9: The mask register sits at index two, eight bits, read-write, resets to zero.
// R10: Several force bits in one write act independently in the same cycle.
package fcm_pkg;

   localparam int unsigned CH_N      = 8;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 32;

   // Register indices; the byte address of each is four times its index.
   localparam logic [5:0]  IDX_FORCE  = 6'h01;
   localparam logic [5:0]  IDX_MASK   = 6'h02;
   localparam logic [5:0]  IDX_DATA7  = 6'h03;
   localparam logic [5:0]  IDX_SELECT = 6'h04;
   localparam logic [5:0]  IDX_DISC   = 6'h05;
   localparam logic [5:0]  IDX_TOV    = 6'h06;
   localparam logic [5:0]  IDX_MODE   = 6'h07;
   localparam logic [5:0]  IDX_FLAG   = 6'h08;
   localparam logic [5:0]  IDX_PIN    = 6'h09;

   // Reset values, and the fixed read value of the force register.
   localparam logic [7:0]  RST_MASK   = 8'h00;
   localparam logic [7:0]  RST_DATA7  = 8'h00;
   localparam logic [7:0]  RST_SELECT = 8'h00;
   localparam logic [7:0]  RST_DISC   = 8'h00;
   localparam logic [7:0]  RST_TOV    = 8'h00;
   localparam logic [15:0] RST_MODE   = 16'h0000;
   localparam logic [7:0]  RST_FLAG   = 8'h00;
   localparam logic [7:0]  RST_PIN    = 8'h00;
   localparam logic [15:0] FORCE_READ = 16'h0000;

   // Bus response codes.
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Compare action of a channel, two bits per channel in the mode register.
   typedef enum logic [1:0] {
      ACT_NONE   = 2'b00,
      ACT_TOGGLE = 2'b01,
      ACT_CLEAR  = 2'b10,
      ACT_SET    = 2'b11
   } fcm_act_t;

   // Software configuration that steers the pin logic.
   typedef struct packed {
      logic [15:0] mode;
      logic [7:0]  sel;
      logic [7:0]  disc;
      logic [7:0]  tov;
      logic [7:0]  mask;
      logic [7:0]  data7;
   } fcm_cfg_t;

   // Compare events arriving in one cycle.
   typedef struct packed {
      logic [7:0]  match;
      logic [7:0]  force_bits;
      logic        overflow;
   } fcm_evt_t;

endpackage

// [hw/fcm_pin_logic.sv]
// Next-value logic for the eight timer output pins.
`timescale 1ns/1ns
`default_nettype none
module fcm_pin_logic #(
   parameter int unsigned CH_N = fcm_pkg::CH_N
) (
   // Present state
   input  wire logic [CH_N-1:0] pin,
   // Configuration and events
   input  wire fcm_pkg::fcm_cfg_t cfg,
   input  wire fcm_pkg::fcm_evt_t evt,
   // Result
   output logic [CH_N-1:0]      next_pin
);

   // Applies one compare action to the present pin level.
   function automatic logic apply_action(input logic [1:0] code, input logic cur);
      logic res;
      res = cur;
      unique case (fcm_pkg::fcm_act_t'(code))
         fcm_pkg::ACT_NONE:   res = cur;
         fcm_pkg::ACT_TOGGLE: res = ~cur;
         fcm_pkg::ACT_CLEAR:  res = 1'b0;
         fcm_pkg::ACT_SET:    res = 1'b1;
      endcase
      return res;
   endfunction

   logic ch7_event;

   // A forced compare on channel 7 counts as a channel-7 event as well.
   assign ch7_event = (evt.overflow & cfg.tov[7]) | evt.match[7] | evt.force_bits[7]; // R4 R2

   always_comb
   begin
      next_pin = pin;
      for (int i = 0; i < CH_N; i++)
      begin
         // Each channel handles its own force or match independently.
         if (evt.match[i] || evt.force_bits[i]) // R1 R2 R10
         begin
            next_pin[i] = apply_action(cfg.mode[2*i +: 2], pin[i]);
         end
         if (evt.overflow && cfg.tov[i])
         begin
            next_pin[i] = ~next_pin[i];
         end
         // Channel-7 data overrides the channel's own compare when masked in.
         if (ch7_event && cfg.mask[i]) // R4 R6 R7
         begin
            next_pin[i] = cfg.data7[i];
         end
         // A pin not set for output compare or disconnected is left alone.
         if (!cfg.sel[i] || cfg.disc[i]) // R8
         begin
            next_pin[i] = pin[i];
         end
      end
   end

endmodule // fcm_pin_logic
`default_nettype wire

// [hw/fcm_top.sv]
// Force-compare and channel-7 mask block with its AXI4-Lite register slave.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module fcm_top #(
   parameter int unsigned CH_N = fcm_pkg::CH_N
) (
   // Clock, reset and enable
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       ce,
   // AXI4-Lite write address
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [fcm_pkg::ADDR_W-1:0] awaddr,
   input  wire logic [2:0]                 awprot,
   // AXI4-Lite write data
   input  wire logic                       wvalid,
   output logic                            wready,
   input  wire logic [fcm_pkg::DATA_W-1:0] wdata,
   input  wire logic [3:0]                 wstrb,
   // AXI4-Lite write response
   output logic                            bvalid,
   input  wire logic                       bready,
   output logic [1:0]                      bresp,
   // AXI4-Lite read address
   input  wire logic                       arvalid,
   output logic                            arready,
   input  wire logic [fcm_pkg::ADDR_W-1:0] araddr,
   input  wire logic [2:0]                 arprot,
   // AXI4-Lite read data
   output logic                            rvalid,
   input  wire logic                       rready,
   output logic [fcm_pkg::DATA_W-1:0]      rdata,
   output logic [1:0]                      rresp,
   // Timer counter and comparators
   input  wire logic [CH_N-1:0]            cmp_match,
   input  wire logic                       cnt_overflow,
   // Timer pins and flags
   output logic [CH_N-1:0]                 timer_pin,
   output logic [CH_N-1:0]                 timer_pin_oe,
   output logic [CH_N-1:0]                 cmp_flag
);

   // True when a byte address selects the register of the given index.
   function automatic logic is_reg(input logic [fcm_pkg::ADDR_W-1:0] addr,
                                   input logic [5:0] idx);
      return addr[fcm_pkg::ADDR_W-1:2] == idx;
   endfunction

   // True when a byte address falls on any mapped register.
   function automatic logic is_mapped(input logic [fcm_pkg::ADDR_W-1:0] addr);
      return is_reg(addr, fcm_pkg::IDX_FORCE)  || is_reg(addr, fcm_pkg::IDX_MASK)
          || is_reg(addr, fcm_pkg::IDX_DATA7)  || is_reg(addr, fcm_pkg::IDX_SELECT)
          || is_reg(addr, fcm_pkg::IDX_DISC)   || is_reg(addr, fcm_pkg::IDX_TOV)
          || is_reg(addr, fcm_pkg::IDX_MODE)   || is_reg(addr, fcm_pkg::IDX_FLAG)
          || is_reg(addr, fcm_pkg::IDX_PIN);
   endfunction

   // Bus state.
   logic                       aw_got;
   logic                       next_aw_got;
   logic                       w_got;
   logic                       next_w_got;
   logic [fcm_pkg::ADDR_W-1:0] wr_addr;
   logic [fcm_pkg::ADDR_W-1:0] next_wr_addr;
   logic [fcm_pkg::DATA_W-1:0] wr_data;
   logic [fcm_pkg::DATA_W-1:0] next_wr_data;
   logic [3:0]                 wr_strb;
   logic [3:0]                 next_wr_strb;
   logic                       next_awready;
   logic                       next_wready;
   logic                       next_bvalid;
   logic [1:0]                 next_bresp;
   logic                       next_arready;
   logic                       next_rvalid;
   logic [fcm_pkg::DATA_W-1:0] next_rdata;
   logic [1:0]                 next_rresp;
   logic                       do_write;

   // Register state.
   fcm_pkg::fcm_cfg_t          cfg;
   fcm_pkg::fcm_cfg_t          next_cfg;
   logic [CH_N-1:0]            next_flag;
   logic [CH_N-1:0]            next_pin;
   logic [CH_N-1:0]            next_pin_oe;
   logic [CH_N-1:0]            force_now;
   logic [CH_N-1:0]            flag_clr;
   fcm_pkg::fcm_evt_t          evt;

   assign do_write = aw_got && w_got && !bvalid;

   always_comb
   begin
      next_aw_got  = aw_got;
      next_w_got   = w_got;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (awvalid && awready)
      begin
         next_aw_got  = 1'b1;
         next_wr_addr = awaddr;
      end
      if (wvalid && wready)
      begin
         next_w_got   = 1'b1;
         next_wr_data = wdata;
         next_wr_strb = wstrb;
      end
      if (do_write)
      begin
         next_aw_got = 1'b0;
         next_w_got  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = is_mapped(wr_addr) ? fcm_pkg::RESP_OKAY : fcm_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
         next_bvalid = 1'b0;
      end
      if (arvalid && arready)
      begin
         next_rvalid = 1'b1;
         next_rresp  = is_mapped(araddr) ? fcm_pkg::RESP_OKAY : fcm_pkg::RESP_SLVERR;
         next_rdata  = '0;
         if (is_reg(araddr, fcm_pkg::IDX_FORCE))
         begin
            // The force strobe lasts one cycle, so nothing is left to read.
            next_rdata = 32'(fcm_pkg::FORCE_READ); // R3
         end
         else if (is_reg(araddr, fcm_pkg::IDX_MASK))
         begin
            next_rdata = 32'(cfg.mask); // R9
         end
         else if (is_reg(araddr, fcm_pkg::IDX_DATA7))
         begin
            next_rdata = 32'(cfg.data7);
         end
         else if (is_reg(araddr, fcm_pkg::IDX_SELECT))
         begin
            next_rdata = 32'(cfg.sel);
         end
         else if (is_reg(araddr, fcm_pkg::IDX_DISC))
         begin
            next_rdata = 32'(cfg.disc);
         end
         else if (is_reg(araddr, fcm_pkg::IDX_TOV))
         begin
            next_rdata = 32'(cfg.tov);
         end
         else if (is_reg(araddr, fcm_pkg::IDX_MODE))
         begin
            next_rdata = 32'(cfg.mode);
         end
         else if (is_reg(araddr, fcm_pkg::IDX_FLAG))
         begin
            next_rdata = 32'(cmp_flag);
         end
         else if (is_reg(araddr, fcm_pkg::IDX_PIN))
         begin
            next_rdata = 32'(timer_pin);
         end
      end
      else if (rvalid && rready)
      begin
         next_rvalid = 1'b0;
      end
      next_awready = !next_aw_got && !next_bvalid;
      next_wready  = !next_w_got && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         aw_got  <= 1'b0;
         w_got   <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= fcm_pkg::RESP_OKAY;
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= fcm_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         aw_got  <= next_aw_got;
         w_got   <= next_w_got;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         awready <= next_awready;
         wready  <= next_wready;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // Register writes; low byte lane carries the eight-bit registers.
   always_comb
   begin
      next_cfg  = cfg;
      force_now = '0;
      flag_clr  = '0;
      if (do_write && wr_strb[0])
      begin
         if (is_reg(wr_addr, fcm_pkg::IDX_FORCE))
         begin
            // All set bits fire together as one strobe.
            force_now = wr_data[CH_N-1:0]; // R1 R3 R10
         end
         if (is_reg(wr_addr, fcm_pkg::IDX_MASK))
         begin
            next_cfg.mask = wr_data[7:0]; // R9
         end
         if (is_reg(wr_addr, fcm_pkg::IDX_DATA7))
         begin
            next_cfg.data7 = wr_data[7:0];
         end
         if (is_reg(wr_addr, fcm_pkg::IDX_SELECT))
         begin
            next_cfg.sel = wr_data[7:0];
         end
         if (is_reg(wr_addr, fcm_pkg::IDX_DISC))
         begin
            next_cfg.disc = wr_data[7:0];
         end
         if (is_reg(wr_addr, fcm_pkg::IDX_TOV))
         begin
            next_cfg.tov = wr_data[7:0];
         end
         if (is_reg(wr_addr, fcm_pkg::IDX_MODE))
         begin
            next_cfg.mode[7:0] = wr_data[7:0];
         end
         if (is_reg(wr_addr, fcm_pkg::IDX_FLAG))
         begin
            flag_clr = wr_data[CH_N-1:0];
         end
      end
      if (do_write && wr_strb[1] && is_reg(wr_addr, fcm_pkg::IDX_MODE))
      begin
         next_cfg.mode[15:8] = wr_data[15:8];
      end
   end

   assign evt.match      = cmp_match;
   assign evt.force_bits = force_now;
   assign evt.overflow   = cnt_overflow;

   fcm_pin_logic #(
      .CH_N     (CH_N)
   ) u_pin_logic (
      .pin      (timer_pin),
      .cfg      (cfg),
      .evt      (evt),
      .next_pin (next_pin)
   );

   always_comb
   begin
      // A genuine match raises its flag unless forced in the same cycle.
      next_flag = (cmp_flag & ~flag_clr) | (cmp_match & ~force_now); // R2 R5
      next_pin_oe = next_cfg.sel & ~next_cfg.disc; // R8
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         cfg.mask     <= fcm_pkg::RST_MASK; // R9
         cfg.data7    <= fcm_pkg::RST_DATA7;
         cfg.sel      <= fcm_pkg::RST_SELECT;
         cfg.disc     <= fcm_pkg::RST_DISC;
         cfg.tov      <= fcm_pkg::RST_TOV;
         cfg.mode     <= fcm_pkg::RST_MODE;
         cmp_flag     <= fcm_pkg::RST_FLAG;
         timer_pin    <= fcm_pkg::RST_PIN;
         timer_pin_oe <= '0;
      end
      else if (ce)
      begin
         cfg          <= next_cfg;
         cmp_flag     <= next_flag;
         timer_pin    <= next_pin;
         timer_pin_oe <= next_pin_oe;
      end
   end

endmodule // fcm_top
`default_nettype wire

// [test/fcm_chk_sva.sv]
// Port checker for the force-compare block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module fcm_chk_sva #(
   parameter int unsigned CH_N = 8
) (
   // Clock, reset and enable
   input wire logic                       clk_sys,
   input wire logic                       rst_n,
   input wire logic                       ce,
   // Register bus
   input wire logic                       awvalid,
   input wire logic                       awready,
   input wire logic                       wvalid,
   input wire logic                       wready,
   input wire logic                       bvalid,
   input wire logic                       bready,
   input wire logic                       arvalid,
   input wire logic                       arready,
   input wire logic [fcm_pkg::ADDR_W-1:0] araddr,
   input wire logic                       rvalid,
   input wire logic                       rready,
   input wire logic [fcm_pkg::DATA_W-1:0] rdata,
   input wire logic [1:0]                 rresp,
   // Timer side
   input wire logic [CH_N-1:0]            cmp_match,
   input wire logic [CH_N-1:0]            timer_pin,
   input wire logic [CH_N-1:0]            timer_pin_oe,
   input wire logic [CH_N-1:0]            cmp_flag
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_wr_take;
      awvalid && awready && wvalid && wready && ce;
   endsequence
   sequence s_rd_take;
      arvalid && arready && ce;
   endsequence

   chk_force_reads_zero: assert property (s_rd_take ##0 araddr[7:2] == fcm_pkg::IDX_FORCE
      |=> rvalid && rdata == 32'h0000_0000) else $error("force register read not zero");
   chk_read_answer: assert property (s_rd_take |=> rvalid && !arready)
      else $error("read not answered next cycle");
   chk_unmapped_read: assert property (s_rd_take ##0
      (araddr[7:2] == 6'h00 || araddr[7:2] > fcm_pkg::IDX_PIN)
      |=> rresp == fcm_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   chk_write_answer: assert property (s_wr_take ##1 ce |-> !bvalid ##1 bvalid)
      else $error("write response not two cycles after take");
   chk_wresp_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");
   chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
   chk_flag_cause: assert property ((cmp_flag & ~$past(cmp_flag) & ~$past(cmp_match)) == '0)
      else $error("flag set without a match");
   chk_pin_held: assert property (((timer_pin ^ $past(timer_pin)) & ~$past(timer_pin_oe)) == '0)
      else $error("pin moved while not driven");
endmodule // fcm_chk_sva

bind fcm_top fcm_chk_sva #(.CH_N(CH_N)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
   .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
   .rresp(rresp), .cmp_match(cmp_match), .timer_pin(timer_pin),
   .timer_pin_oe(timer_pin_oe), .cmp_flag(cmp_flag)
);
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the force-compare block.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        clk_sys, rst_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, cnt_overflow;
   logic [7:0]  awaddr, araddr, cmp_match, timer_pin, timer_pin_oe, cmp_flag;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [2:0]  awprot, arprot;
   logic [1:0]  bresp, rresp, wr_resp, rd_resp;
   int          mismatches = 0;
   int          comparisons = 0;
   // Edges to wait before raising bready or rready, so that a slow master is exercised too.
   int          bus_hold = 0;

   fcm_top dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .cmp_match(cmp_match), .cnt_overflow(cnt_overflow), .timer_pin(timer_pin),
      .timer_pin_oe(timer_pin_oe), .cmp_flag(cmp_flag)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_up();
      mismatches++;
      $display("[FAIL] bus answer expected within bound seen none");
      tally_and_finish();
   endtask

   // Match pulse m lands on the edge that applies the written data.
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [7:0] m);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int k = 0; k < 40; k++)
      begin
         @(posedge clk_sys);
         if (k < 2)
            cmp_match <= (k == 0) ? m : 8'h00;
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            bready <= 1'b0;
            wr_resp = bresp;
            return;
         end
         if (k >= bus_hold)
            bready <= 1'b1;
      end
      give_up();
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      araddr <= a;
      arvalid <= 1'b1;
      for (int k = 0; k < 40; k++)
      begin
         @(posedge clk_sys);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            rready <= 1'b0;
            v = rdata;
            rd_resp = rresp;
            return;
         end
         if (k >= bus_hold)
            rready <= 1'b1;
      end
      give_up();
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      rd(a, v);
      check(what, v, exp);
   endtask

   task automatic pulse(input logic [7:0] m, input logic ov);
      cmp_match <= m;
      cnt_overflow <= ov;
      @(posedge clk_sys);
      cmp_match <= 8'h00;
      cnt_overflow <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
   endtask

   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, cnt_overflow} = '0;
      {awaddr, araddr, cmp_match, wdata, awprot, arprot} = '0;
      ce = 1'b1;
      wstrb = 4'hF;
      do_reset();
      #1;
      check("oe after reset", timer_pin_oe, 8'h00);
      rchk(8'h08, 32'h0000_0000, "mask reset");
      rchk(8'h04, 32'h0000_0000, "force read");
      bus_hold = 2;
      wr(8'h08, 32'h0000_015A, 8'h00);
      check("mask write resp", wr_resp, fcm_pkg::RESP_OKAY);
      rchk(8'h08, 32'h0000_005A, "mask rw");
      check("mask read resp", rd_resp, fcm_pkg::RESP_OKAY);
      bus_hold = 0;
      rd(8'h3C, d);
      check("unmapped read", rd_resp, fcm_pkg::RESP_SLVERR);
      wr(8'h3C, 32'h0000_00FF, 8'h00);
      check("unmapped write", wr_resp, fcm_pkg::RESP_SLVERR);
      $display("test registers done");
      wr(8'h10, 32'h0000_00FF, 8'h00);
      wr(8'h1C, 32'h0000_001F, 8'h00);
      wr(8'h08, 32'h0000_0000, 8'h00);
      wr(8'h04, 32'h0000_0007, 8'h00);
      check("force set toggle", timer_pin, 8'h07);
      check("force flag", cmp_flag, 8'h00);
      rchk(8'h04, 32'h0000_0000, "force read back");
      wr(8'h1C, 32'h0000_0012, 8'h00);
      wr(8'h04, 32'h0000_0005, 8'h00);
      check("force clear toggle", timer_pin, 8'h02);
      wr(8'h04, 32'h0000_0001, 8'h03);
      check("force with match flag", cmp_flag, 8'h02);
      check("force with match pin", timer_pin, 8'h02);
      wr(8'h20, 32'h0000_0002, 8'h00);
      rchk(8'h20, 32'h0000_0000, "flag clear");
      $display("test force done");
      do_reset();
      wr(8'h10, 32'h0000_00BF, 8'h00);
      wr(8'h14, 32'h0000_0020, 8'h00);
      wr(8'h18, 32'h0000_0080, 8'h00);
      wr(8'h1C, 32'h0000_5555, 8'h00);
      wr(8'h08, 32'h0000_006F, 8'h00);
      wr(8'h0C, 32'h0000_0065, 8'h00);
      #1;
      check("oe config", timer_pin_oe, 8'h9F);
      pulse(8'h7F, 1'b1);
      check("overflow event pins", timer_pin, 8'h95);
      wr(8'h0C, 32'h0000_000A, 8'h00);
      pulse(8'h80, 1'b0);
      check("match event pins", timer_pin, 8'h1A);
      // A match on a toggling channel while disabled must leave every pin as it was.
      ce <= 1'b0;
      pulse(8'h10, 1'b0);
      ce <= 1'b1;
      check("pins frozen while disabled", timer_pin, 8'h1A);
      rchk(8'h24, 32'h0000_001A, "pin register");
      rchk(8'h20, 32'h0000_00FF, "match flags");
      $display("test channel 7 done");
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
